/* rtl/sms_pkg.sv */
// shared constants and types of the serial master/slave port
package sms_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // enable, role, length, select level
    localparam logic [7:0] OFS_BAUD   = 8'h04;  // master half period control
    localparam logic [7:0] OFS_DATA   = 8'h08;  // write: transmit, read: received
    localparam logic [7:0] OFS_STATUS = 8'h0C;  // sticky events, write one to clear
    localparam logic [7:0] OFS_MASK   = 8'h10;  // interrupt mask, same layout as status

    ////////////////////////////////////////////////////////////////////////
    // control field positions
    localparam int CTRL_EN     = 0;  // port enabled
    localparam int CTRL_MASTER = 1;  // 1: master, 0: slave
    localparam int CTRL_LEN16  = 2;  // 1: 16-bit characters, 0: 8-bit
    localparam int CTRL_SSPOL  = 3;  // active level of slave select
    localparam int CTRL_W      = 4;  // width of the control register

    // status and mask field positions
    localparam int ST_DONE = 0;  // character complete
    localparam int ST_COLL = 1;  // collision seen while master
    localparam int ST_BUSY = 2;  // read only, master transfer in progress
    localparam int ST_W    = 2;  // sticky bits only

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;   // disabled slave, 8-bit, low select
    localparam logic [7:0]        BAUD_RST   = 8'h00;  // fastest legal master rate
    localparam logic [15:0]       DATA_RST   = 16'h0000;
    localparam logic [ST_W-1:0]   STATUS_RST = 2'h0;
    localparam logic [ST_W-1:0]   MASK_RST   = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // timing: system clock, and the shortest serial clock half period in cycles
    localparam int          SYS_CLK_NS   = 40;     // 25 MHz system clock
    localparam logic [8:0]  MIN_HALF_CYC = 9'h002; // two cycles keeps master at or below sysclk/2
    localparam logic [4:0]  BITS_SHORT   = 5'h08;  // short character
    localparam logic [4:0]  BITS_LONG    = 5'h10;  // long character

    // master engine states, one-hot
    typedef enum logic [1:0] {
        MS_IDLE = 2'b01,
        MS_RUN  = 2'b10
    } sms_state_t;

endpackage

/* rtl/sms_pin_if.sv */
// synchronised view of one serial pin, handed from the synchroniser to the port
interface sms_pin_if;
    logic lvl;   // pin level after two flip-flops
    logic rise;  // one-cycle pulse on a low to high change
    logic fall;  // one-cycle pulse on a high to low change

    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface

/* rtl/sms_sync.sv */
// two flip-flop synchroniser with edge detection for one serial pin
module sms_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic pin,
    sms_pin_if.src    pout
);

    logic s1_reg;  // metastable stage, only s2 reads it
    logic s2_reg;  // stable level
    logic s3_reg;  // previous stable level for edges

    ////////////////////////////////////////////////////////////////////////
    // shift the pin through the chain, frozen while ce is low
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // edges come from the stable stages only
    assign pout.lvl  = s2_reg;
    assign pout.rise = s2_reg & ~s3_reg;
    assign pout.fall = ~s2_reg & s3_reg;

endmodule // sms_sync

/* rtl/sms_port.sv */
// serial master/slave port with wishbone registers and one interrupt
//
// Contract
// - port works as master or as slave
// - four wires, one bit each way per clock
// - detect another master driving the bus
// - master serial clock at most sysclk/2
// - slave handles external clock up to sysclk/4
// - 8 or 16 bit characters, msb first
// - programmable select level, selected only then
// - exchange synchronous to the current master's clock
module sms_port (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic        CE,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             IRQ,
    input  wire logic        SCLK_I,
    output logic             SCLK_O,
    output logic             SCLK_OE,
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE,
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE,
    input  wire logic        SSEL_I,
    output logic             SSO
);

    ////////////////////////////////////////////////////////////////////////
    // synchronised pins
    sms_pin_if sclk_p ();  // serial clock from another master
    sms_pin_if mosi_p ();  // data in while slave
    sms_pin_if miso_p ();  // data in while master
    sms_pin_if ssel_p ();  // select in, collision sense while master

    sms_sync u_sclk (.clk(MCLK), .rst(RESET), .ce(CE), .pin(SCLK_I), .pout(sclk_p));
    sms_sync u_mosi (.clk(MCLK), .rst(RESET), .ce(CE), .pin(MOSI_I), .pout(mosi_p));
    sms_sync u_miso (.clk(MCLK), .rst(RESET), .ce(CE), .pin(MISO_I), .pout(miso_p));
    sms_sync u_ssel (.clk(MCLK), .rst(RESET), .ce(CE), .pin(SSEL_I), .pout(ssel_p));

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [sms_pkg::CTRL_W-1:0] ctrl_reg;     // control register
    logic [sms_pkg::CTRL_W-1:0] ctrl_next;
    logic [7:0]                 baud_reg;     // half period is baud + 2 cycles
    logic [15:0]                tx_reg;       // next character to send
    logic [15:0]                rx_reg;       // last completed character
    logic [sms_pkg::ST_W-1:0]   status_reg;   // sticky events
    logic [sms_pkg::ST_W-1:0]   status_next;
    logic [sms_pkg::ST_W-1:0]   mask_reg;     // interrupt enables
    logic [15:0]                sh_reg;       // shared shift register
    logic [4:0]                 bit_reg;      // bits done in this character
    logic [8:0]                 half_reg;     // cycles within a half period
    logic                       sel_reg;      // slave selection seen last cycle
    sms_pkg::sms_state_t        state_reg;    // master engine

    ////////////////////////////////////////////////////////////////////////
    // configuration decode
    wire en      = ctrl_reg[sms_pkg::CTRL_EN];
    wire master  = ctrl_reg[sms_pkg::CTRL_MASTER];
    wire len16   = ctrl_reg[sms_pkg::CTRL_LEN16];
    wire sspol   = ctrl_reg[sms_pkg::CTRL_SSPOL];
    wire [4:0] nbits = len16 ? sms_pkg::BITS_LONG : sms_pkg::BITS_SHORT;
    wire ss_act  = (ssel_p.lvl == sspol);
    wire running = (state_reg == sms_pkg::MS_RUN);

    // another master pulls our select while we are master
    wire coll_set = en & master & ss_act;
    // slave is selected only at the configured level
    wire slv_sel   = en & ~master & ss_act;
    wire sel_start = slv_sel & ~sel_reg;

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode, one wait-free answer per request
    wire req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr      = req & WB_WE_I;
    wire hit_ctl = (WB_ADR_I == sms_pkg::OFS_CTRL);
    wire hit_bd  = (WB_ADR_I == sms_pkg::OFS_BAUD);
    wire hit_dat = (WB_ADR_I == sms_pkg::OFS_DATA);
    wire hit_st  = (WB_ADR_I == sms_pkg::OFS_STATUS);
    wire hit_msk = (WB_ADR_I == sms_pkg::OFS_MASK);
    wire [31:0] lane = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wire [31:0] wdat = WB_DAT_I & lane;
    wire wr_dat  = wr & hit_dat & (WB_SEL_I[1:0] != 2'b00);

    // read mux, unmapped offsets answer zero
    wire [31:0] rd_data =
        hit_ctl ? {28'h0000000, ctrl_reg} :
        hit_bd  ? {24'h000000, baud_reg} :
        hit_dat ? {16'h0000, rx_reg} :
        hit_st  ? {29'h00000000, running, status_reg} :
        hit_msk ? {30'h00000000, mask_reg} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // shifter datapath shared by both roles
    wire in_bit  = master ? miso_p.lvl : mosi_p.lvl;
    wire [15:0] sh_shift = {sh_reg[14:0], in_bit};
    wire tx_msb  = len16 ? tx_reg[15] : tx_reg[7];
    wire nx_msb  = len16 ? sh_reg[14] : sh_reg[6];
    wire last    = ((bit_reg + 5'h01) == nbits);
    wire [15:0] rx_cap = len16 ? sh_shift : {8'h00, sh_shift[7:0]};

    // master timing: half period of baud + MIN_HALF_CYC cycles
    wire half_end = (half_reg == ({1'b0, baud_reg} + sms_pkg::MIN_HALF_CYC - 9'h001));
    wire start_m  = wr_dat & master & en & ~running & ~coll_set;
    wire m_fall   = running & half_end & SCLK_O & ~coll_set;   // sample on the falling edge
    wire m_rise   = running & half_end & ~SCLK_O & ~coll_set;
    // slave follows only the external clock edges
    wire s_rise   = slv_sel & ~sel_start & sclk_p.rise;
    wire m_done   = m_fall & last;
    wire s_done   = s_rise & last;
    wire done_set = m_done | s_done;

    ////////////////////////////////////////////////////////////////////////
    // register next values; hardware set wins over software clear
    localparam int ST_W_C = sms_pkg::ST_W;
    wire [ST_W_C-1:0] st_clr = (wr & hit_st) ? wdat[sms_pkg::ST_W-1:0] : 2'h0;

    always_comb begin
        status_next = (status_reg & ~st_clr);
        status_next[sms_pkg::ST_DONE] = status_next[sms_pkg::ST_DONE] | done_set;
        status_next[sms_pkg::ST_COLL] = status_next[sms_pkg::ST_COLL] | coll_set;
        ctrl_next = ctrl_reg;
        if (wr & hit_ctl) begin
            ctrl_next = wdat[sms_pkg::CTRL_W-1:0];
        end
        // a collision drops the port to slave so it frees the bus
        if (coll_set) begin
            ctrl_next[sms_pkg::CTRL_MASTER] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer and software registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            WB_ACK_O   <= 1'b0;
            WB_DAT_O   <= 32'h00000000;
            ctrl_reg   <= sms_pkg::CTRL_RST;
            baud_reg   <= sms_pkg::BAUD_RST;
            tx_reg     <= sms_pkg::DATA_RST;
            status_reg <= sms_pkg::STATUS_RST;
            mask_reg   <= sms_pkg::MASK_RST;
            IRQ        <= 1'b0;
        end else if (CE) begin
            WB_ACK_O   <= req;
            WB_DAT_O   <= req ? rd_data : 32'h00000000;
            ctrl_reg   <= ctrl_next;
            status_reg <= status_next;
            IRQ        <= |(status_next & mask_reg);
            if (wr & hit_bd) begin
                baud_reg <= wdat[7:0];
            end
            // transmit is not overwritten under a running master character
            if (wr_dat & ~running) begin
                tx_reg <= wdat[15:0];
            end
            if (wr & hit_msk) begin
                mask_reg <= wdat[sms_pkg::ST_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master engine and shifter
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_reg <= sms_pkg::MS_IDLE;
            half_reg  <= 9'h000;
            sh_reg    <= 16'h0000;
            bit_reg   <= 5'h00;
            rx_reg    <= sms_pkg::DATA_RST;
            sel_reg   <= 1'b0;
            SCLK_O    <= 1'b0;
            MOSI_O    <= 1'b0;
            MISO_O    <= 1'b0;
        end else if (CE) begin
            sel_reg  <= slv_sel;
            half_reg <= (running & ~half_end) ? half_reg + 9'h001 : 9'h000;
            case (state_reg)
                sms_pkg::MS_IDLE: begin
                    if (start_m) begin
                        state_reg <= sms_pkg::MS_RUN;
                        sh_reg    <= wdat[15:0];
                        MOSI_O    <= len16 ? wdat[15] : wdat[7];
                        bit_reg   <= 5'h00;
                        SCLK_O    <= 1'b0;
                    end else begin
                        SCLK_O    <= 1'b0;  // an aborted clock drops a cycle later, never a runt
                    end
                end
                sms_pkg::MS_RUN: begin
                    if (coll_set) begin
                        state_reg <= sms_pkg::MS_IDLE;  // clock level is returned by idle
                        bit_reg   <= 5'h00;
                    end else if (m_rise) begin
                        SCLK_O <= 1'b1;
                    end else if (m_fall) begin
                        SCLK_O  <= 1'b0;
                        sh_reg  <= sh_shift;
                        bit_reg <= bit_reg + 5'h01;
                        MOSI_O  <= nx_msb;
                        if (last) begin
                            state_reg <= sms_pkg::MS_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= sms_pkg::MS_IDLE;
                end
            endcase
            // slave side: load on selection, shift on each rising clock
            if (sel_start) begin
                sh_reg  <= tx_reg;
                bit_reg <= 5'h00;
                MISO_O  <= tx_msb;
            end else if (s_rise) begin
                sh_reg  <= last ? tx_reg : sh_shift;
                bit_reg <= last ? 5'h00 : bit_reg + 5'h01;
                MISO_O  <= last ? tx_msb : nx_msb;
            end else if (~slv_sel & ~master) begin
                bit_reg <= 5'h00;  // deselect drops a partial character
            end
            if (done_set) begin
                rx_reg <= rx_cap;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers: only the active role drives, collision releases at once
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            SCLK_OE <= 1'b0;
            MOSI_OE <= 1'b0;
            MISO_OE <= 1'b0;
            SSO     <= 1'b1;
        end else if (CE) begin
            SCLK_OE <= en & master & ~coll_set;
            MOSI_OE <= en & master & ~coll_set;
            MISO_OE <= slv_sel;
            // own select toward the addressed slave, active only while running
            SSO     <= (running & ~coll_set & ~m_done) | start_m ? sspol : ~sspol;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_half_rate;
        @(posedge MCLK) disable iff (RESET)
        (CE && $changed(SCLK_O)) |=> !$changed(SCLK_O);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("serial clock faster than half");

    property p_coll_release;
        @(posedge MCLK) disable iff (RESET)
        (CE && coll_set) |=> (!SCLK_OE && !MOSI_OE && state_reg == sms_pkg::MS_IDLE);
    endproperty
    a_coll_release: assert property (p_coll_release) else $error("outputs held after collision");

    property p_coll_flag;
        @(posedge MCLK) disable iff (RESET)
        (CE && coll_set) |=> status_reg[sms_pkg::ST_COLL] && !ctrl_reg[sms_pkg::CTRL_MASTER];
    endproperty
    a_coll_flag: assert property (p_coll_flag) else $error("collision not flagged");

    property p_done_flag;
        @(posedge MCLK) disable iff (RESET)
        (CE && done_set) |=> status_reg[sms_pkg::ST_DONE] && rx_reg == $past(rx_cap);
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("character not captured");

    property p_slave_quiet;
        @(posedge MCLK) disable iff (RESET)
        (CE && !slv_sel) |=> !MISO_OE;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("miso driven unselected");

    property p_len_bound;
        @(posedge MCLK) disable iff (RESET)
        running |-> (bit_reg < nbits);
    endproperty
    a_len_bound: assert property (p_len_bound) else $error("bit count past length");

    property p_mosi_msb;
        @(posedge MCLK) disable iff (RESET)
        (CE && start_m) |=> MOSI_O == (len16 ? sh_reg[15] : sh_reg[7]);
    endproperty
    a_mosi_msb: assert property (p_mosi_msb) else $error("first bit is not msb");

    property p_role_excl;
        @(posedge MCLK) disable iff (RESET)
        !(SCLK_OE && MISO_OE);
    endproperty
    a_role_excl: assert property (p_role_excl) else $error("both roles drive");

    property p_slave_shift;
        @(posedge MCLK) disable iff (RESET)
        (CE && s_rise && !last) |=> sh_reg[0] == $past(mosi_p.lvl);
    endproperty
    a_slave_shift: assert property (p_slave_shift) else $error("slave missed input bit");

    c_master_done: cover property (@(posedge MCLK) disable iff (RESET) m_done);
    c_slave_done:  cover property (@(posedge MCLK) disable iff (RESET) s_done);
    c_collision:   cover property (@(posedge MCLK) disable iff (RESET) coll_set && running);
    c_long_char:   cover property (@(posedge MCLK) disable iff (RESET) done_set && len16);

endmodule // sms_port

/* tb/sms_peer.sv */
// behavioural far side of the serial port: external slave or external master
module sms_peer (
    input  wire logic sclk_o,
    input  wire logic sclk_oe,
    input  wire logic mosi_o,
    input  wire logic mosi_oe,
    input  wire logic miso_o,
    input  wire logic sso,
    output logic      sclk_w,
    output logic      mosi_w,
    output logic      miso_w,
    output logic      ssel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        pol = 1'b0;      // select level in use
    int          len = 8;         // character length in use
    logic [15:0] tx  = 16'h0000;  // character we send back
    logic [15:0] rx  = 16'h0000;  // character we received
    logic        ps  = 1'b0;      // our clock, still between frames
    logic        pm  = 1'b0;      // our data toward the port
    logic        mo  = 1'b0;      // our data on the slave output line
    int          k   = 0;         // bit index while we act as slave

    // shared wires: the port wins sclk and mosi while it drives them, miso carries only our bit
    assign sclk_w = (sclk_oe === 1'b1) ? sclk_o : ps;
    assign mosi_w = (mosi_oe === 1'b1) ? mosi_o : pm;
    assign miso_w = mo;
    initial ssel = 1'b1;

    ////////////////////////////////////////////////////////////
    // slave role: msb first, first bit on select, next after each fall
    always @(sso) begin
        if (sso === pol) begin
            k = len - 1;
            mo = tx[k];
        end else begin
            mo = ~mo;  // released line must not keep a stale bit
        end
    end
    always @(posedge sclk_o) if (sclk_oe === 1'b1) rx = {rx[14:0], mosi_o};
    always @(negedge sclk_o) begin
        if (sclk_oe === 1'b1 && k > 0) begin
            k = k - 1;
            mo = tx[k];
        end
    end

    ////////////////////////////////////////////////////////////
    // master role: 320 ns clock only inside the frame, odd phase offset
    task automatic frame(input logic sl, input logic [15:0] d, output logic [15:0] got);
        got = 16'h0000;
        #7 ssel = sl ? pol : ~pol;
        #640;
        for (int i = len - 1; i >= 0; i--) begin
            #80 pm = d[i];  // set mid low phase so the late synced sample still holds it
            #80 ps = 1'b1;
            got = {got[14:0], miso_o};
            #160 ps = 1'b0;
        end
        #640 ssel = ~pol;
        pm = ~pm;  // released data line shows no stale value
    endtask
endmodule // sms_peer

/* tb/tb_spi_master_slave_port.sv */
// self-checking bench of the serial master/slave port
module tb_spi_master_slave_port;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string n; logic [31:0] e; logic [31:0] m;} sms_note_t;
    logic        mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [31:0] dat  = 32'h0, seed = 32'h832DD669;
    logic [31:0] dat_o;
    logic        ack, irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, sso;
    wire         sclk_w, mosi_w, miso_w, ssel;
    logic [15:0] tx, got, m;
    int          err_total = 0, checks = 0, baud = 0, hc = 0;
    logic        seen = 1'b0, lastc = 1'b0;
    sms_note_t   q[$];  // expected read data, oldest first

    always #20 mclk = ~mclk;

    sms_port uut (.MCLK(mclk), .RESET(reset), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .IRQ(irq), .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe),
        .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w),
        .MISO_O(miso_o), .MISO_OE(miso_oe), .SSEL_I(ssel), .SSO(sso));
    sms_peer peer (.sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_o(miso_o), .sso(sso), .sclk_w(sclk_w), .mosi_w(mosi_w), .miso_w(miso_w),
        .ssel(ssel));

    ////////////////////////////////////////////////////////////
    // helpers: compare, verdict, random source, bus cycles
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic void nxt();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    endfunction
    // hold the request until the edge that samples ack, release after it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        t = 0;
        // ack is read as it stood at the edge, before that edge's updates
        do begin
            @(posedge mclk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (ack !== 1'b1) begin
            $display("Error wb_ack expected 1 seen %b", ack);
            err_total++;
            stop_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] mk);
        q.push_back('{n, e, mk});
        wb(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq;
        int t;
        t = 0;
        while (irq !== 1'b1 && t < 2000) begin
            @(negedge mclk);
            t++;
        end
        if (irq !== 1'b1) begin
            $display("Error irq expected 1 seen %b", irq);
            err_total++;
            stop_test();
        end
    endtask
    // disable first so a select level change cannot start a stray character
    task automatic cfg(input logic ms, input logic l16, input logic pl);
        wr(sms_pkg::OFS_CTRL, 32'h0);
        peer.pol = pl;
        peer.len = l16 ? 16 : 8;
        peer.ssel = ~pl;
        m = l16 ? 16'hFFFF : 16'h00FF;
        wr(sms_pkg::OFS_CTRL, {28'h0, pl, l16, ms, 1'b1});
    endtask

    ////////////////////////////////////////////////////////////
    // read monitor: takes the oldest note when read data is acked
    always @(negedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            sms_note_t nt;
            nt = q.pop_front();
            chk(nt.n, nt.e & nt.m, dat_o & nt.m);
        end
    end
    // every master half period after the first and before the last is baud plus two cycles
    always @(negedge mclk) begin
        hc++;
        if (sclk_oe !== 1'b1 || sso !== peer.pol) seen = 1'b0;
        else if (sclk_o !== lastc) begin
            if (seen) chk("half_period", 32'(baud + 2), 32'(hc));
            seen = 1'b1;
            hc = 0;
        end
        lastc = sclk_o;
    end

    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        for (int a = 0; a <= 20; a += 4) rd("reset_value", 8'(a), 32'h0, 32'hFFFFFFFF);
        wr(sms_pkg::OFS_MASK, 32'h3);
        // master: both lengths, both select levels, a refused busy write
        for (int i = 0; i < 4; i++) begin
            nxt();
            cfg(1'b1, i[0], i[1]);
            baud = int'(seed[1:0]);
            wr(sms_pkg::OFS_BAUD, 32'(baud));
            peer.tx = seed[31:16];
            tx = seed[15:0];
            wr(sms_pkg::OFS_DATA, {16'h0, tx});
            wr(sms_pkg::OFS_DATA, {16'h0, ~tx});
            rd("busy", sms_pkg::OFS_STATUS, 32'h4, 32'h4);
            wait_irq();
            chk("peer_rx", {16'h0, tx & m}, {16'h0, peer.rx & m});
            rd("master_rx", sms_pkg::OFS_DATA, {16'h0, peer.tx & m}, '1);
            rd("done", sms_pkg::OFS_STATUS, 32'h1, 32'h7);
            wr(sms_pkg::OFS_STATUS, 32'h3);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
        // slave: both lengths and levels, interrupt masked on short characters
        for (int i = 0; i < 4; i++) begin
            nxt();
            cfg(1'b0, i[0], i[1]);
            wr(sms_pkg::OFS_MASK, {31'h0, i[0]});
            tx = seed[15:0];
            wr(sms_pkg::OFS_DATA, {16'h0, tx});
            peer.frame(1'b1, seed[31:16], got);
            chk("miso_bits", {16'h0, tx & m}, {16'h0, got & m});
            chk("irq_mask", {31'h0, i[0]}, {31'h0, irq});
            rd("slave_rx", sms_pkg::OFS_DATA, {16'h0, seed[31:16] & m}, '1);
            rd("done", sms_pkg::OFS_STATUS, 32'h1, 32'h3);
            wr(sms_pkg::OFS_STATUS, 32'h1);
        end
        // clocks while select sits at the idle level are ignored
        peer.frame(1'b0, 16'h00A5, got);
        rd("unselected", sms_pkg::OFS_STATUS, 32'h0, 32'h3);
        chk("miso_oe", 32'h0, {31'h0, miso_oe});
        // collision: another master selects us in mid character
        cfg(1'b1, 1'b1, 1'b0);
        baud = 15;
        wr(sms_pkg::OFS_BAUD, 32'h0000000F);
        wr(sms_pkg::OFS_MASK, 32'h2);
        wr(sms_pkg::OFS_DATA, 32'h0000A5A5);
        repeat (100) @(negedge mclk);
        peer.ssel = 1'b0;
        wait_irq();
        repeat (4) @(negedge mclk);
        chk("sclk_oe", 32'h0, {31'h0, sclk_oe});
        chk("mosi_oe", 32'h0, {31'h0, mosi_oe});
        rd("coll", sms_pkg::OFS_STATUS, 32'h2, 32'h3);
        rd("ctrl_after", sms_pkg::OFS_CTRL, 32'h5, '1);
        peer.ssel = 1'b1;
        wr(sms_pkg::OFS_STATUS, 32'h2);
        rd("coll_clear", sms_pkg::OFS_STATUS, 32'h0, 32'h3);
        chk("irq_off", 32'h0, {31'h0, irq});
        stop_test();
    end
endmodule // tb_spi_master_slave_port
